// >>> src/pdmc_pkg.sv
// package: register map, field layout and timing constants for the power-down controller
`default_nettype none
package pdmc_pkg;
   localparam logic [15:0] PDMC_SYSCTL_ADDR = 16'hffc4;
   localparam logic [15:0] PDMC_STATUS_ADDR = 16'hffc8;
   localparam logic [7:0] PDMC_SYSCTL_RST = 8'h09;
   localparam int PDMC_STANDBY_SELECT_BIT_BIT = 7;
   localparam int PDMC_STS_HI = 6;
   localparam int PDMC_STS_LO = 4;
   localparam int PDMC_RESET_SOURCE_FLAG_BIT = 3;
   localparam int PDMC_NMI_EDGE_SELECT_BIT = 2;
   localparam int PDMC_HIE_BIT = 1;
   localparam int PDMC_ONCHIP_RAM_ENABLE_BIT = 0;
   localparam logic [7:0] PDMC_WR_MASK = 8'hf7;
   localparam int PDMC_CNT_W = 18;
   localparam logic [PDMC_CNT_W-1:0] PDMC_SETTLE_8K = 18'h02000;
   localparam logic [PDMC_CNT_W-1:0] PDMC_SETTLE_16K = 18'h04000;
   localparam logic [PDMC_CNT_W-1:0] PDMC_SETTLE_32K = 18'h08000;
   localparam logic [PDMC_CNT_W-1:0] PDMC_SETTLE_64K = 18'h10000;
   localparam logic [PDMC_CNT_W-1:0] PDMC_SETTLE_128K = 18'h20000;
   localparam logic [PDMC_CNT_W-1:0] PDMC_SETTLE_1K = 18'h00400;
   typedef enum logic [2:0]
   {
      PDMC_RUN = 3'h0,
      PDMC_SLEEP = 3'h1,
      PDMC_SWSTBY = 3'h2,
      PDMC_SETTLE = 3'h3,
      PDMC_HWSTBY = 3'h4,
      PDMC_RESET = 3'h5
   } pdmc_state_t;
endpackage : pdmc_pkg
`default_nettype wire

// >>> src/pdmc_settle_timer.sv
// settling counter: counts system clock cycles after the oscillator restarts
`default_nettype none
module pdmc_settle_timer
   import pdmc_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // control
   input wire logic start,
   input wire logic [2:0] sel,
   input wire logic flash_variant,
   // result
   output logic done
);
   typedef struct packed
   {
      logic [PDMC_CNT_W-1:0] cnt;
      logic run;
      logic done;
   } pdmc_tmr_t;

   pdmc_tmr_t st_ff;
   pdmc_tmr_t nxt_st;

   // unused codes fall back to the longest wait, the safe side
   function automatic logic [PDMC_CNT_W-1:0] settle_len(input logic [2:0] s, input logic fl);
      case (s)
         3'h0: settle_len = PDMC_SETTLE_8K;
         3'h1: settle_len = PDMC_SETTLE_16K;
         3'h2: settle_len = PDMC_SETTLE_32K;
         3'h3: settle_len = PDMC_SETTLE_64K;
         3'h5: settle_len = fl ? PDMC_SETTLE_1K : PDMC_SETTLE_128K;
         default: settle_len = PDMC_SETTLE_128K;
      endcase
   endfunction : settle_len

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.done = 1'b0;
      if (start)
      begin
         nxt_st.run = 1'b1;
         nxt_st.cnt = settle_len(sel, flash_variant) - 18'h00001;
      end
      else if (st_ff.run)
      begin
         if (st_ff.cnt == '0)
         begin
            nxt_st.run = 1'b0;
            nxt_st.done = 1'b1;
         end
         else
         begin
            nxt_st.cnt = st_ff.cnt - 18'h00001;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign done = st_ff.done;
endmodule : pdmc_settle_timer
`default_nettype wire

// >>> src/pdmc_ctrl.sv
// power-down mode controller: sleep, software standby and hardware standby sequencing
`default_nettype none
// Notes on behaviour
// - halt with standby select 0 enters sleep; CPU stops, clock and peripherals run.
// - halt with standby select 1 enters software standby instead.
// - software standby stops clock, resets peripherals, keeps CPU registers, RAM, pins.
// - an accepted internal or external interrupt ends sleep and starts handling.
// - disabled peripheral interrupts raise no request and cannot wake sleep.
// - mask set at halt lets only the non-maskable interrupt wake sleep.
// - reset pin low during sleep goes to the reset state.
// - standby pin low during sleep goes straight to hardware standby.
// - software standby ends on nmi, lines 0-2 or 6, keys, reset or standby pin.
// - standby pin low from any state enters hardware standby; pins float.
// - leave hardware standby with standby high, reset low, then reset rising.
// - standby select stays 1 after an interrupt wake until software writes 0.
// - standby select at bit 7, settle select at bits 6 to 4 of system control.
// - settle codes 000..100 give 8192..131072 clock states; 000 at reset.
// - flash variant code 101 gives 1024 states; codes 11x unused.
// - during settling the oscillator runs while CPU and peripherals stay held.
module pdmc_ctrl
   import pdmc_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // cpu core and interrupt logic
   input wire logic halt_exec,
   input wire logic cpu_imask,
   input wire logic nmi_req,
   input wire logic [7:0] irq_req,
   input wire logic [7:0] key_wake_inputs,
   input wire logic periph_irq_req,
   input wire logic flash_variant,
   // external pins
   input wire logic reset_pin_n,
   input wire logic hw_standby_pin_n,
   // power control
   output logic cpu_halt,
   output logic clk_stop,
   output logic osc_run,
   output logic periph_reset,
   output logic periph_halt,
   output logic pins_hiz,
   output logic chip_reset,
   output logic irq_start,
   output logic [2:0] mode_state
);
   typedef struct packed
   {
      pdmc_state_t st;
      logic [7:0] sysctl;
      logic ack;
      logic [31:0] dat;
      logic cpu_halt;
      logic clk_stop;
      logic osc_run;
      logic periph_reset;
      logic periph_halt;
      logic pins_hiz;
      logic chip_reset;
      logic irq_start;
      logic mask_at_halt;
      logic [PDMC_CNT_W-1:0] settle_cyc;
   } pdmc_ctrl_t;

   pdmc_ctrl_t st_ff;
   pdmc_ctrl_t nxt_st;
   logic tmr_start;
   logic tmr_done;
   logic sw_wake;
   logic sleep_wake;

   function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] r);
      addr_hit = (a[15:2] == r[15:2]);
   endfunction : addr_hit

   // only these sources restart the oscillator from software standby
   assign sw_wake = nmi_req | (|irq_req[2:0]) | irq_req[6] | (|key_wake_inputs);
   // a disabled peripheral source never asserts periph_irq_req
   // the mask captured at halt blocks all but nmi
   assign sleep_wake = nmi_req |
      (~st_ff.mask_at_halt & ((|irq_req) | periph_irq_req));
   assign tmr_start = (st_ff.st == PDMC_SWSTBY) && sw_wake && hw_standby_pin_n && reset_pin_n;

   pdmc_settle_timer u_settle
   (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .start(tmr_start),
      .sel(st_ff.sysctl[PDMC_STS_HI:PDMC_STS_LO]),
      .flash_variant(flash_variant),
      .done(tmr_done)
   );

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.ack = 1'b0;
      nxt_st.irq_start = 1'b0;
      // one-wait-state slave: ack one cycle after the request, then drops
      if (wb_cyc_i && wb_stb_i && !st_ff.ack)
      begin
         nxt_st.ack = 1'b1;
         nxt_st.dat = 32'h00000000;
         if (addr_hit(wb_adr_i, PDMC_SYSCTL_ADDR))
         begin
            nxt_st.dat = {24'h000000, st_ff.sysctl};
            if (wb_we_i && wb_sel_i[0])
            begin
               // standby select changes only by a software write or the reset load on standby pin low or reset exit
               nxt_st.sysctl = (wb_dat_i[7:0] & PDMC_WR_MASK) |
                  (st_ff.sysctl & ~PDMC_WR_MASK);
            end
         end
         else if (addr_hit(wb_adr_i, PDMC_STATUS_ADDR))
         begin
            nxt_st.dat = {29'h00000000, st_ff.st};
         end
      end
      // cycles since the oscillator restart; a counter keeps the length checks cheap
      if (tmr_start)
      begin
         nxt_st.settle_cyc = '0;
      end
      else if (st_ff.st == PDMC_SETTLE)
      begin
         nxt_st.settle_cyc = st_ff.settle_cyc + 18'h00001;
      end
      case (st_ff.st)
         PDMC_RUN:
         begin
            if (halt_exec)
            begin
               nxt_st.mask_at_halt = cpu_imask;
               nxt_st.cpu_halt = 1'b1;
               if (st_ff.sysctl[PDMC_STANDBY_SELECT_BIT_BIT])
               begin
                  nxt_st.st = PDMC_SWSTBY;
                  nxt_st.clk_stop = 1'b1;
                  nxt_st.osc_run = 1'b0;
                  nxt_st.periph_halt = 1'b1;
                  nxt_st.periph_reset = 1'b1;
               end
               else
               begin
                  nxt_st.st = PDMC_SLEEP;
               end
            end
         end
         PDMC_SLEEP:
         begin
            if (!reset_pin_n)
            begin
               nxt_st.st = PDMC_RESET;
               nxt_st.chip_reset = 1'b1;
            end
            else if (sleep_wake)
            begin
               nxt_st.st = PDMC_RUN;
               nxt_st.cpu_halt = 1'b0;
               nxt_st.irq_start = 1'b1;
            end
         end
         PDMC_SWSTBY:
         begin
            if (!reset_pin_n)
            begin
               nxt_st.st = PDMC_RESET;
               nxt_st.osc_run = 1'b1;
               nxt_st.chip_reset = 1'b1;
            end
            else if (tmr_start)
            begin
               nxt_st.st = PDMC_SETTLE;
               nxt_st.osc_run = 1'b1;
            end
         end
         PDMC_SETTLE:
         begin
            if (!reset_pin_n)
            begin
               nxt_st.st = PDMC_RESET;
               nxt_st.chip_reset = 1'b1;
            end
            else if (tmr_done)
            begin
               nxt_st.st = PDMC_RUN;
               nxt_st.clk_stop = 1'b0;
               nxt_st.cpu_halt = 1'b0;
               nxt_st.periph_halt = 1'b0;
               nxt_st.periph_reset = 1'b0;
               nxt_st.irq_start = 1'b1;
            end
         end
         PDMC_HWSTBY:
         begin
            if (hw_standby_pin_n)
            begin
               nxt_st.st = PDMC_RESET;
               nxt_st.pins_hiz = 1'b0;
               nxt_st.osc_run = 1'b1;
            end
         end
         PDMC_RESET:
         begin
            // chip stays in reset until the reset pin rises
            if (reset_pin_n)
            begin
               nxt_st = '0;
               nxt_st.st = PDMC_RUN;
               nxt_st.osc_run = 1'b1;
               nxt_st.sysctl = PDMC_SYSCTL_RST;
            end
            else
            begin
               nxt_st.chip_reset = 1'b1;
               nxt_st.cpu_halt = 1'b1;
               nxt_st.periph_reset = 1'b1;
               nxt_st.periph_halt = 1'b1;
               nxt_st.clk_stop = 1'b0;
               nxt_st.osc_run = 1'b1;
            end
         end
         default:
         begin
            nxt_st.st = PDMC_RESET;
         end
      endcase
      if (!hw_standby_pin_n)
      begin
         // standby pin overrides every state; only RAM survives
         nxt_st.st = PDMC_HWSTBY;
         nxt_st.cpu_halt = 1'b1;
         nxt_st.clk_stop = 1'b1;
         nxt_st.osc_run = 1'b0;
         nxt_st.periph_halt = 1'b1;
         nxt_st.periph_reset = 1'b1;
         nxt_st.pins_hiz = 1'b1;
         nxt_st.chip_reset = 1'b1;
         nxt_st.irq_start = 1'b0;
         nxt_st.sysctl = PDMC_SYSCTL_RST;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         st_ff <= '{st: PDMC_RUN, sysctl: PDMC_SYSCTL_RST, osc_run: 1'b1, default: '0};
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign wb_dat_o = st_ff.dat;
   assign wb_ack_o = st_ff.ack;
   assign cpu_halt = st_ff.cpu_halt;
   assign clk_stop = st_ff.clk_stop;
   assign osc_run = st_ff.osc_run;
   assign periph_reset = st_ff.periph_reset;
   assign periph_halt = st_ff.periph_halt;
   assign pins_hiz = st_ff.pins_hiz;
   assign chip_reset = st_ff.chip_reset;
   assign irq_start = st_ff.irq_start;
   assign mode_state = st_ff.st;

   chk_sleep_entry: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (st_ff.st == PDMC_RUN && halt_exec && !st_ff.sysctl[7] && hw_standby_pin_n)
      |=> (st_ff.st == PDMC_SLEEP && cpu_halt && !clk_stop))
      else $error("halt with select 0 did not enter sleep");
   chk_swstby_entry: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (st_ff.st == PDMC_RUN && halt_exec && st_ff.sysctl[7] && hw_standby_pin_n)
      |=> (st_ff.st == PDMC_SWSTBY && clk_stop && periph_reset))
      else $error("halt with select 1 did not enter software standby");
   chk_sleep_wake: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (st_ff.st == PDMC_SLEEP && nmi_req && reset_pin_n && hw_standby_pin_n)
      |=> (irq_start && !cpu_halt))
      else $error("nmi did not end sleep");
   chk_mask_blocks: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (st_ff.st == PDMC_SLEEP && st_ff.mask_at_halt && !nmi_req && reset_pin_n
       && hw_standby_pin_n) |=> (st_ff.st == PDMC_SLEEP))
      else $error("masked interrupt woke sleep");
   chk_sleep_reset: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (st_ff.st == PDMC_SLEEP && !reset_pin_n && hw_standby_pin_n)
      |=> (st_ff.st == PDMC_RESET && chip_reset))
      else $error("reset pin did not reset from sleep");
   chk_hwstby_any: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !hw_standby_pin_n |=> (st_ff.st == PDMC_HWSTBY && pins_hiz && clk_stop))
      else $error("standby pin low did not enter hardware standby");
   chk_hwstby_exit: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (st_ff.st == PDMC_HWSTBY && hw_standby_pin_n) |=> (st_ff.st == PDMC_RESET && !pins_hiz))
      else $error("hardware standby exit did not go to reset");
   chk_select_kept: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (st_ff.st == PDMC_SETTLE && tmr_done && reset_pin_n && hw_standby_pin_n)
      |=> (st_ff.sysctl[7] && irq_start))
      else $error("standby select lost on interrupt wake");
   chk_settle_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (st_ff.st == PDMC_SETTLE) |-> (osc_run && cpu_halt && periph_halt))
      else $error("cpu or peripherals released during settling");
   chk_settle_len: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (st_ff.st == PDMC_SETTLE && tmr_done && flash_variant && st_ff.sysctl[6:4] == 3'h5)
      |-> (st_ff.settle_cyc == PDMC_SETTLE_1K))
      else $error("1024-state settle wrong length");
   chk_settle_base: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (st_ff.st == PDMC_SETTLE && tmr_done && st_ff.sysctl[6:4] == 3'h0)
      |-> (st_ff.settle_cyc == PDMC_SETTLE_8K))
      else $error("8192-state settle wrong length");
   cov_sleep: cover property (@(posedge ref_clk) st_ff.st == PDMC_SLEEP ##1 irq_start);
   cov_swwake: cover property (@(posedge ref_clk) st_ff.st == PDMC_SETTLE ##1 irq_start);
   cov_hwstby: cover property (@(posedge ref_clk) st_ff.st == PDMC_HWSTBY ##1
      st_ff.st == PDMC_RESET);
endmodule : pdmc_ctrl
`default_nettype wire

// >>> test/pdmc_cpu_model.sv
// model of the cpu core, interrupt sources and external pins facing the controller
`default_nettype none
module pdmc_cpu_model
(
   // clock and controller feedback
   input wire logic ref_clk,
   input wire logic irq_start,
   // cpu and interrupt side
   output logic halt_exec,
   output logic cpu_imask,
   output logic nmi_req,
   output logic [7:0] irq_req,
   output logic [7:0] key_wake_inputs,
   output logic periph_irq_req,
   output logic flash_variant,
   // external pins
   output logic reset_pin_n,
   output logic hw_standby_pin_n
);
   timeunit 1ns;
   timeprecision 1ps;

   task withdraw;
      nmi_req <= 1'b0;
      irq_req <= 8'h00;
      key_wake_inputs <= 8'h00;
      periph_irq_req <= 1'b0;
   endtask : withdraw

   // one-cycle halt strobe; the mask is captured by the controller on the same edge
   task pulse_halt(input logic imask);
      cpu_imask <= imask;
      halt_exec <= 1'b1;
      @(posedge ref_clk);
      halt_exec <= 1'b0;
   endtask : pulse_halt

   // 0..7 external line, 8 nmi, 9 key, 10 enabled peripheral source
   task request(input int src);
      if (src == 8)
         nmi_req <= 1'b1;
      else if (src == 9)
         key_wake_inputs <= 8'hff;
      else if (src == 10)
         periph_irq_req <= 1'b1;
      else
         irq_req[src] <= 1'b1;
   endtask : request

   // replaces the whole set of external lines in one assignment
   task raise_lines(input logic [7:0] m);
      irq_req <= m;
   endtask : raise_lines

   task set_variant(input logic f);
      flash_variant <= f;
   endtask : set_variant

   task set_pins(input logic rst_n, input logic hw_standby_pin_n_n);
      reset_pin_n <= rst_n;
      hw_standby_pin_n <= hw_standby_pin_n_n;
   endtask : set_pins

   initial
   begin
      halt_exec = 1'b0;
      cpu_imask = 1'b0;
      flash_variant = 1'b0;
      reset_pin_n = 1'b1;
      hw_standby_pin_n = 1'b1;
      withdraw();
   end

   // an accepted request is taken down, so a level never wakes twice
   always @(posedge ref_clk)
   begin
      if (irq_start)
         withdraw();
   end
endmodule : pdmc_cpu_model
`default_nettype wire

// >>> test/power_down_mode_control_bench.sv
// self-checking bench for the power-down mode controller
`default_nettype none
module power_down_mode_control_bench;
   import pdmc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [15:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic halt_exec, cpu_imask, nmi_req, periph_irq_req, flash_variant;
   logic [7:0] irq_req, key_wake_inputs;
   logic reset_pin_n, hw_standby_pin_n, irq_start;
   logic cpu_halt, clk_stop, osc_run, periph_reset, periph_halt, pins_hiz, chip_reset;
   logic [2:0] mode_state;
   logic [6:0] outs;
   int miscompares = 0;
   int num_checks = 0;
   int srcs[6] = '{0, 1, 2, 6, 8, 9};
   assign outs = {cpu_halt, clk_stop, osc_run, periph_reset, periph_halt, pins_hiz, chip_reset};

   pdmc_ctrl DUT (.ref_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .halt_exec, .cpu_imask, .nmi_req, .irq_req,
      .key_wake_inputs, .periph_irq_req, .flash_variant, .reset_pin_n, .hw_standby_pin_n,
      .cpu_halt, .clk_stop, .osc_run, .periph_reset, .periph_halt, .pins_hiz, .chip_reset,
      .irq_start, .mode_state);
   pdmc_cpu_model cpu (.ref_clk, .irq_start, .halt_exec, .cpu_imask, .nmi_req, .irq_req,
      .key_wake_inputs, .periph_irq_req, .flash_variant, .reset_pin_n, .hw_standby_pin_n);

   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : give_verdict

   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick

   // classic cycle: held until ack is sampled high, then one idle cycle
   task wb_xfer(input logic we, input logic [15:0] adr, input logic [7:0] wd,
      output logic [31:0] rd);
      int k;
      k = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= {24'h000000, wd};
      do
      begin
         @(posedge ref_clk);
         k++;
      end
      while (wb_ack_o !== 1'b1 && k < 20);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      if (k >= 20)
      begin
         miscompares++;
         give_verdict();
      end
      @(posedge ref_clk);
   endtask : wb_xfer

   task wr(input logic [15:0] adr, input logic [7:0] d);
      logic [31:0] r;
      wb_xfer(1'b1, adr, d, r);
   endtask : wr

   task rd(input logic [15:0] adr, input logic [31:0] exp);
      logic [31:0] r;
      wb_xfer(1'b0, adr, 8'h00, r);
      check("register read", r, exp);
   endtask : rd

   task chk_mode(input logic [2:0] st, input logic [6:0] exp, input logic [6:0] msk);
      check("mode_state", 32'(mode_state), 32'(st));
      check("power outputs", 32'(outs & msk), 32'(exp & msk));
   endtask : chk_mode

   // edges from the wake request until the handling strobe
   task wait_wake(input int n);
      int k;
      k = 0;
      do
      begin
         @(posedge ref_clk);
         k++;
      end
      while (irq_start !== 1'b1 && k < n + 50);
      check("wake delay in range", 32'(k >= n && k <= n + 4), 32'h1);
      if (irq_start !== 1'b1)
         give_verdict();
   endtask : wait_wake

   initial
   begin
      sys_rst = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 16'h0000;
      wb_sel_i = 4'h1;
      wb_dat_i = 32'h0;
      tick(5);
      sys_rst <= 1'b0;
      tick(1);
      rd(PDMC_SYSCTL_ADDR, 32'h09);
      chk_mode(PDMC_RUN, 7'h10, 7'h7f);
      wr(PDMC_SYSCTL_ADDR, 8'h00);
      rd(PDMC_SYSCTL_ADDR, 32'h08);
      rd(PDMC_STATUS_ADDR, 32'h0);
      rd(16'hffcc, 32'h0);
      cpu.pulse_halt(1'b1);
      tick(2);
      chk_mode(PDMC_SLEEP, 7'h50, 7'h7f);
      cpu.request(3);
      tick(5);
      chk_mode(PDMC_SLEEP, 7'h50, 7'h7f);
      cpu.request(8);
      wait_wake(1);
      tick(2);
      chk_mode(PDMC_RUN, 7'h10, 7'h7f);
      cpu.pulse_halt(1'b0);
      tick(2);
      cpu.request(10);
      wait_wake(1);
      tick(2);
      cpu.pulse_halt(1'b0);
      tick(2);
      cpu.set_pins(1'b0, 1'b1);
      tick(2);
      chk_mode(PDMC_RESET, 7'h01, 7'h01);
      cpu.set_pins(1'b1, 1'b1);
      tick(2);
      cpu.pulse_halt(1'b0);
      tick(2);
      cpu.set_pins(1'b1, 1'b0);
      tick(2);
      chk_mode(PDMC_HWSTBY, 7'h02, 7'h02);
      cpu.set_pins(1'b0, 1'b1);
      tick(2);
      chk_mode(PDMC_RESET, 7'h01, 7'h01);
      cpu.set_pins(1'b1, 1'b1);
      tick(2);
      chk_mode(PDMC_RUN, 7'h10, 7'h7f);
      rd(PDMC_SYSCTL_ADDR, 32'h09);
      wr(PDMC_SYSCTL_ADDR, 8'h80);
      cpu.pulse_halt(1'b0);
      tick(2);
      chk_mode(PDMC_SWSTBY, 7'h6c, 7'h7f);
      cpu.raise_lines(8'hb8);
      tick(4);
      chk_mode(PDMC_SWSTBY, 7'h6c, 7'h7f);
      cpu.raise_lines(8'h40);
      tick(2);
      chk_mode(PDMC_SETTLE, 7'h50, 7'h50);
      wait_wake(8190);
      tick(2);
      rd(PDMC_SYSCTL_ADDR, 32'h88);
      wb_sel_i <= 4'he;
      wr(PDMC_SYSCTL_ADDR, 8'h00);
      wb_sel_i <= 4'hf;
      rd(PDMC_SYSCTL_ADDR, 32'h88);
      wr(PDMC_SYSCTL_ADDR, 8'h90);
      cpu.pulse_halt(1'b0);
      tick(2);
      cpu.request(8);
      wait_wake(16384);
      tick(2);
      cpu.set_variant(1'b1);
      wr(PDMC_SYSCTL_ADDR, 8'hd0);
      foreach (srcs[i])
      begin
         cpu.pulse_halt(1'b0);
         tick(2);
         chk_mode(PDMC_SWSTBY, 7'h6c, 7'h7f);
         cpu.request(srcs[i]);
         wait_wake(1024);
         tick(2);
      end
      wr(PDMC_SYSCTL_ADDR, 8'h00);
      rd(PDMC_SYSCTL_ADDR, 32'h08);
      give_verdict();
   end
endmodule : power_down_mode_control_bench
`default_nettype wire
